// ### core/twd_pkg.sv
package twd_pkg;

  // ***********************************************************
  // target register select values
  // ***********************************************************
  localparam logic [7:0] SEL_PART_ID     = 8'h00;
  localparam logic [7:0] SEL_REVISION    = 8'h01;
  localparam logic [7:0] SEL_FP_CONTROL  = 8'h02;
  localparam logic [7:0] SEL_FP_DATA     = 8'hB4;

  // ***********************************************************
  // flash command codes
  // ***********************************************************
  localparam logic [7:0] CODE_BLOCK_READ   = 8'h06;
  localparam logic [7:0] CODE_BLOCK_WRITE  = 8'h07;
  localparam logic [7:0] CODE_PAGE_ERASE   = 8'h08;
  localparam logic [7:0] CODE_DEVICE_ERASE = 8'h03;

  // ***********************************************************
  // reset values
  // ***********************************************************
  localparam logic [7:0] SELECT_RESET  = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET    = 8'h00;

  // ***********************************************************
  // link framing
  // ***********************************************************
  localparam logic [1:0] INS_DATA_READ  = 2'h0;
  localparam logic [1:0] INS_DATA_WRITE = 2'h1;
  localparam logic [1:0] INS_ADDR_READ  = 2'h2;
  localparam logic [1:0] INS_ADDR_WRITE = 2'h3;
  localparam logic [2:0] INS_LAST_BIT   = 3'h1;
  localparam logic [2:0] BYTE_LAST_BIT  = 3'h7;

  typedef enum logic [1:0] {
    TWD_LINK_IDLE,
    TWD_LINK_INS,
    TWD_LINK_WRITE,
    TWD_LINK_READ
  } twd_link_state_t;

  typedef enum logic [2:0] {
    TWD_OP_NONE,
    TWD_OP_BLOCK_READ,
    TWD_OP_BLOCK_WRITE,
    TWD_OP_PAGE_ERASE,
    TWD_OP_DEVICE_ERASE
  } twd_flash_op_t;

  typedef struct packed {
    logic          valid;
    logic          is_command;
    twd_flash_op_t op;
    logic [7:0]    value;
  } twd_flash_req_t;

endpackage

// ### core/twd_debug_port.sv
`timescale 1ns/1ns
// Notes on behaviour
// [RULE1] host clocks the port on one line; data moves on one two-way line.
// [RULE2] debug registers are reachable only through debug link transactions.
// [RULE3] target select value steers which register a data read or write reaches.
// [RULE4] select 0x00: data read returns the part identity register.
// [RULE5] select 0x01: data read returns the silicon revision register.
// [RULE6] select 0x02: data read and write reach the flash program control register.
// [RULE7] select 0xB4: data read and write reach the flash program data register.
// [RULE8] commands, addresses and data bytes all pass through the flash program data register.
// [RULE9] code 0x06 is a block read, code 0x07 a block write.
// [RULE10] code 0x08 is a page erase, code 0x03 erases the whole device.
// [RULE11] host talks to the port only while the device is halted.
// [RULE12] while halted, the port borrows the reset pin clock and the data pin.
// [RULE13] user input sharing the data pin stays still while halted.
// [RULE14] application uses the reset pin as an input only.
// [RULE15] data writes to part identity or silicon revision are ignored.
module twd_debug_port #(
  parameter logic [7:0] PART_ID  = 8'h5A,  // arbitrary value
  parameter logic [7:0] REVISION = 8'h01   // arbitrary value
) (
  input  wire logic                    clock,
  input  wire logic                    nrst,
  input  wire logic                    debug_clock_line,
  input  wire logic                    debug_data_line_in,
  output logic                         debug_data_line_out,
  output logic                         debug_data_line_oe_n,
  input  wire logic                    halted,
  input  wire logic                    flash_done,
  input  wire logic                    flash_rd_valid,
  input  wire logic [7:0]              flash_rd_data,
  output twd_pkg::twd_flash_req_t      flash_req,
  output logic                         flash_busy,
  output logic [7:0]                   flash_control
);
  import twd_pkg::*;

  // ***********************************************************
  // link domain state
  // ***********************************************************
  twd_link_state_t state;
  logic [2:0]      bit_cnt;
  logic [1:0]      ins;
  logic [7:0]      shift;
  logic [7:0]      target_register_select;
  logic [7:0]      wr_byte;
  logic            wr_toggle;
  logic [7:0]      fp_data_rd;
  logic            halted_meta;
  logic            halted_link;
  logic            rd_meta;
  logic            rd_sync;
  logic            rd_seen;
  logic [1:0]      next_ins;
  logic [7:0]      next_shift;
  logic [7:0]      read_value;
  logic [7:0]      load_value;
  logic            ins_done;
  logic            ins_is_read;
  logic            write_done;
  logic            read_done;

  // ***********************************************************
  // core domain state
  // ***********************************************************
  logic            req_meta;
  logic            req_sync;
  logic            req_seen;
  logic [7:0]      rd_word;
  logic            rd_toggle;
  twd_flash_op_t   decoded_op;

  assign next_ins   = {debug_data_line_in, ins[1]};
  assign next_shift = {debug_data_line_in, shift[7:1]};

  assign ins_done    = (state == TWD_LINK_INS) && (bit_cnt == INS_LAST_BIT);
  assign ins_is_read = (next_ins == INS_DATA_READ) || (next_ins == INS_ADDR_READ);
  assign write_done  = (state == TWD_LINK_WRITE) && (bit_cnt == BYTE_LAST_BIT);
  assign read_done   = (state == TWD_LINK_READ) && (bit_cnt == BYTE_LAST_BIT);
  assign load_value  = (next_ins == INS_DATA_READ) ? read_value : target_register_select;

  // ***********************************************************
  // selected register read mux
  // ***********************************************************
  always_comb begin
    case (target_register_select)                     // RULE3
      SEL_PART_ID:    read_value = PART_ID;           // RULE4
      SEL_REVISION:   read_value = REVISION;          // RULE5
      SEL_FP_CONTROL: read_value = flash_control;     // RULE6
      SEL_FP_DATA:    read_value = fp_data_rd;        // RULE7
      default:        read_value = 8'h00;
    endcase
  end

  // ***********************************************************
  // halt level into the link domain
  // ***********************************************************
  always_ff @(posedge debug_clock_line or negedge nrst) begin
    if (!nrst) begin
      halted_meta <= 1'b0;
      halted_link <= 1'b0;
    end else begin
      halted_meta <= halted;
      halted_link <= halted_meta;
    end
  end

  // ***********************************************************
  // flash read word handshake, core to link
  // ***********************************************************
  always_ff @(posedge debug_clock_line or negedge nrst) begin
    if (!nrst) begin
      rd_meta    <= 1'b0;
      rd_sync    <= 1'b0;
      rd_seen    <= 1'b0;
      fp_data_rd <= DATA_RESET;
    end else begin
      rd_meta <= rd_toggle;
      rd_sync <= rd_meta;
      rd_seen <= rd_sync;
      if (rd_sync != rd_seen) begin
        fp_data_rd <= rd_word;
      end
    end
  end

  // ***********************************************************
  // link frame sequencing
  // ***********************************************************
  always_ff @(posedge debug_clock_line or negedge nrst) begin     // RULE1 RULE2
    if (!nrst) begin
      state <= TWD_LINK_IDLE;
    end else begin
      case (state)
        TWD_LINK_IDLE: begin
          if (halted_link && !debug_data_line_in) begin          // RULE11 RULE12
            state <= TWD_LINK_INS;
          end
        end
        TWD_LINK_INS: begin
          if (ins_done) begin
            state <= ins_is_read ? TWD_LINK_READ : TWD_LINK_WRITE;
          end
        end
        TWD_LINK_WRITE: begin
          if (write_done) begin
            state <= TWD_LINK_IDLE;
          end
        end
        TWD_LINK_READ: begin
          if (read_done) begin
            state <= TWD_LINK_IDLE;
          end
        end
        default: state <= TWD_LINK_IDLE;
      endcase
    end
  end

  // ***********************************************************
  // bit counter and instruction capture
  // ***********************************************************
  always_ff @(posedge debug_clock_line or negedge nrst) begin
    if (!nrst) begin
      bit_cnt <= 3'h0;
    end else if (state == TWD_LINK_IDLE || ins_done) begin
      bit_cnt <= 3'h0;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  always_ff @(posedge debug_clock_line or negedge nrst) begin
    if (!nrst) begin
      ins <= 2'h0;
    end else if (state == TWD_LINK_INS) begin
      ins <= next_ins;
    end
  end

  // ***********************************************************
  // read data shifter and pin drive
  // ***********************************************************
  always_ff @(posedge debug_clock_line or negedge nrst) begin
    if (!nrst) begin
      debug_data_line_oe_n <= 1'b1;
    end else if (ins_done && ins_is_read) begin
      debug_data_line_oe_n <= 1'b0;                              // RULE1
    end else if (state == TWD_LINK_IDLE || read_done) begin
      debug_data_line_oe_n <= 1'b1;
    end
  end

  always_ff @(posedge debug_clock_line or negedge nrst) begin
    if (!nrst) begin
      shift               <= 8'h00;
      debug_data_line_out <= 1'b1;
    end else if (ins_done && ins_is_read) begin
      debug_data_line_out <= load_value[0];
      shift               <= {1'b0, load_value[7:1]};
    end else if (state == TWD_LINK_WRITE) begin
      shift <= next_shift;
    end else if (state == TWD_LINK_READ && !read_done) begin
      debug_data_line_out <= shift[0];
      shift               <= {1'b0, shift[7:1]};
    end
  end

  // ***********************************************************
  // register writes from the link
  // ***********************************************************
  always_ff @(posedge debug_clock_line or negedge nrst) begin
    if (!nrst) begin
      target_register_select <= SELECT_RESET;
      flash_control          <= CONTROL_RESET;
    end else if (write_done) begin
      if (ins == INS_ADDR_WRITE) begin
        target_register_select <= next_shift;                     // RULE3
      end else begin
        case (target_register_select)                            // RULE15
          SEL_FP_CONTROL: flash_control <= next_shift;           // RULE6
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge debug_clock_line or negedge nrst) begin
    if (!nrst) begin
      wr_byte   <= DATA_RESET;
      wr_toggle <= 1'b0;
    end else if (write_done && ins == INS_DATA_WRITE &&
                 target_register_select == SEL_FP_DATA) begin    // RULE7 RULE8
      wr_byte   <= next_shift;
      wr_toggle <= ~wr_toggle;
    end
  end

  // ***********************************************************
  // flash command decode
  // ***********************************************************
  always_comb begin
    case (wr_byte)
      CODE_BLOCK_READ:   decoded_op = TWD_OP_BLOCK_READ;     // RULE9
      CODE_BLOCK_WRITE:  decoded_op = TWD_OP_BLOCK_WRITE;    // RULE9
      CODE_PAGE_ERASE:   decoded_op = TWD_OP_PAGE_ERASE;     // RULE10
      CODE_DEVICE_ERASE: decoded_op = TWD_OP_DEVICE_ERASE;   // RULE10
      default:           decoded_op = TWD_OP_NONE;
    endcase
  end

  // ***********************************************************
  // data byte handshake, link to core
  // ***********************************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      req_meta <= 1'b0;
      req_sync <= 1'b0;
      req_seen <= 1'b0;
    end else begin
      req_meta <= wr_toggle;
      req_sync <= req_meta;
      req_seen <= req_sync;
    end
  end

  // ***********************************************************
  // flash request issue
  // ***********************************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      flash_req  <= '0;
      flash_busy <= 1'b0;
    end else begin
      flash_req.valid <= 1'b0;
      if (flash_done) begin
        flash_busy <= 1'b0;
      end
      if (req_sync != req_seen) begin                        // RULE8
        flash_req.valid      <= 1'b1;
        flash_req.value      <= wr_byte;
        flash_req.is_command <= !flash_busy && decoded_op != TWD_OP_NONE;
        flash_req.op         <= flash_busy ? TWD_OP_NONE : decoded_op;
        if (!flash_busy && decoded_op != TWD_OP_NONE) begin
          flash_busy <= 1'b1;
        end
      end
    end
  end

  // ***********************************************************
  // flash read data capture
  // ***********************************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rd_word   <= DATA_RESET;
      rd_toggle <= 1'b0;
    end else if (flash_rd_valid) begin
      rd_word   <= flash_rd_data;
      rd_toggle <= ~rd_toggle;
    end
  end

endmodule

// ### sim/twd_host_model.sv
`timescale 1ns/1ns
module twd_host_model (
  output logic      ck,
  output logic      hd,
  output logic      hoe,
  input  wire logic wd
);
  initial begin
    ck = 1'b0;
    hd = 1'b1;
    hoe = 1'b1;
  end
  task automatic bit_out(input logic b);
    hd = b;
    #32 ck = 1'b1;
    #32 ck = 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) bit_out(1'b1);
  endtask
  // ***********************************************************
  // one frame: start, two instruction bits, eight payload bits
  // ***********************************************************
  task automatic frame(input logic [1:0] ins, input logic [7:0] wv,
                       output logic [7:0] rv);
    rv = 8'h00;
    bit_out(1'b0);
    bit_out(ins[0]);
    hd = ins[1];
    #32 ck = 1'b1;
    #1 hoe = ins[0];
    #31 ck = 1'b0;
    for (int k = 0; k < 8; k++) begin
      if (ins[0]) begin
        bit_out(wv[k]);
      end else begin
        rv[k] = wd;
        bit_out(1'b1);
      end
    end
    hoe = 1'b1;
  endtask
endmodule

// ### sim/twd_debug_port_sva.sv
`timescale 1ns/1ns
module twd_debug_port_sva (
  input wire logic                    clock,
  input wire logic                    nrst,
  input wire logic                    debug_clock_line,
  input wire logic                    debug_data_line_oe_n,
  input wire logic                    halted,
  input wire logic                    flash_done,
  input wire twd_pkg::twd_flash_req_t flash_req,
  input wire logic                    flash_busy,
  input wire logic [7:0]              flash_control
);
  import twd_pkg::*;
  wire [7:0] v = flash_req.value;
  wire [2:0] o = flash_req.op;
  cmd_op_a: assert property (@(posedge clock) disable iff (!nrst)
    flash_req.valid && flash_req.is_command |->
      (v == 8'h06 && o == TWD_OP_BLOCK_READ) || (v == 8'h07 && o == TWD_OP_BLOCK_WRITE) ||
      (v == 8'h08 && o == TWD_OP_PAGE_ERASE) || (v == 8'h03 && o == TWD_OP_DEVICE_ERASE))
    else $error("bad command decode");
  busy_set_a: assert property (@(posedge clock) disable iff (!nrst)
    flash_req.valid && flash_req.is_command |-> flash_busy) else $error("busy not set");
  plain_op_a: assert property (@(posedge clock) disable iff (!nrst)
    flash_req.valid && !flash_req.is_command |-> o == TWD_OP_NONE) else $error("plain op");
  busy_clear_a: assert property (@(posedge clock) disable iff (!nrst)
    flash_busy && flash_done |=> !flash_busy)
    else $error("busy not cleared");
  busy_hold_a: assert property (@(posedge clock) disable iff (!nrst)
    flash_busy && !flash_done |=> flash_busy) else $error("busy dropped");
  req_halted_a: assert property (@(posedge clock) disable iff (!nrst)
    flash_req.valid |-> halted) else $error("request while running");
  read_window_a: assert property (@(posedge debug_clock_line) disable iff (!nrst)
    $fell(debug_data_line_oe_n) |-> (!debug_data_line_oe_n)[*8] ##1 debug_data_line_oe_n)
    else $error("read drive window");
  ctl_halted_a: assert property (@(posedge debug_clock_line) disable iff (!nrst)
    !$stable(flash_control) |-> halted) else $error("control changed while running");
  cover property (@(posedge clock) flash_req.valid && flash_req.is_command);
  cover property (@(posedge clock) flash_busy && flash_done);
  cover property (@(posedge debug_clock_line) $fell(debug_data_line_oe_n));
endmodule
bind twd_debug_port twd_debug_port_sva twd_debug_port_sva_i (.clock(clock), .nrst(nrst),
  .debug_clock_line(debug_clock_line), .debug_data_line_oe_n(debug_data_line_oe_n),
  .halted(halted), .flash_done(flash_done), .flash_req(flash_req),
  .flash_busy(flash_busy), .flash_control(flash_control));

// ### sim/two_wire_debug_flash_access_tb_top.sv
`timescale 1ns/1ns
module two_wire_debug_flash_access_tb_top;
  import twd_pkg::*;
  logic           clock, nrst, halted, flash_done, flash_rd_valid, flash_busy;
  logic           ck, hd, hoe, dout, oe_n, line;
  logic [7:0]     flash_rd_data, flash_control, rv;
  twd_flash_req_t flash_req;
  twd_flash_req_t got[$];
  int             err_count = 0, compares = 0, m_sel = 0, m_ctl = CONTROL_RESET, v;
  int             codes[4] = '{6, 7, 8, 3};
  int             ops[4] = '{TWD_OP_BLOCK_READ, TWD_OP_BLOCK_WRITE, TWD_OP_PAGE_ERASE,
                             TWD_OP_DEVICE_ERASE};
  assign line = !oe_n ? dout : (hoe ? hd : 1'b1);
  twd_debug_port #(.PART_ID(8'hA7), .REVISION(8'h3C)) twd_debug_port_i (
    .clock(clock), .nrst(nrst), .debug_clock_line(ck), .debug_data_line_in(line),
    .debug_data_line_out(dout), .debug_data_line_oe_n(oe_n), .halted(halted),
    .flash_done(flash_done), .flash_rd_valid(flash_rd_valid), .flash_rd_data(flash_rd_data),
    .flash_req(flash_req), .flash_busy(flash_busy), .flash_control(flash_control));
  twd_host_model twd_host_model_i (.ck(ck), .hd(hd), .hoe(hoe), .wd(line));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(negedge clock) if (flash_req.valid) got.push_back(flash_req);
  task automatic give_verdict;
    if (err_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input int e);
    compares++;
    if (g !== 8'(e)) begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, g, 8'(e));
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  task automatic wr(input int a, input int d);
    twd_host_model_i.frame(INS_ADDR_WRITE, 8'(a), rv);
    twd_host_model_i.frame(INS_DATA_WRITE, 8'(d), rv);
    m_sel = a;
    if (a == SEL_FP_CONTROL) begin
      m_ctl = d;
    end
  endtask
  task automatic rd(input int a, input int e);
    twd_host_model_i.frame(INS_ADDR_WRITE, 8'(a), rv);
    twd_host_model_i.frame(INS_DATA_READ, 8'h00, rv);
    m_sel = a;
    chk(rv, e);
  endtask
  task automatic fw(input int d, input int e);
    twd_flash_req_t r;
    wr('hB4, d);
    cyc(8);
    chk(8'(got.size()), 1);
    if (got.size() > 0) begin
      r = got.pop_front();
      chk(r.value, d);
      chk({4'h0, r.is_command, r.op}, e);
    end
  endtask
  // ***********************************************************
  // test sequence
  // ***********************************************************
  initial begin
    void'($urandom(32'h9cce));
    {nrst, halted, flash_done, flash_rd_valid, flash_rd_data} = '0;
    cyc(8);
    nrst = 1'b1;
    halted = 1'b1;
    twd_host_model_i.idle(4);
    rd(0, 'hA7);
    wr(0, 'h11);
    rd(0, 'hA7);
    wr(1, 'h22);
    rd(1, 'h3C);
    twd_host_model_i.frame(INS_ADDR_READ, 8'h00, rv);
    chk(rv, m_sel);
    repeat (3) begin
      v = $urandom_range(255);
      rd(2, m_ctl);
      wr(2, v);
      rd(2, v);
      chk(flash_control, v);
    end
    rd('h55, 0);
    for (int i = 0; i < 4; i++) begin
      fw(codes[i], 8 + ops[i]);
      chk({7'h0, flash_busy}, 1);
      fw(codes[3 - i], 0);
      fw($urandom_range(255), 0);
      flash_done = 1'b1;
      cyc(1);
      flash_done = 1'b0;
      cyc(1);
      chk({7'h0, flash_busy}, 0);
    end
    v = $urandom_range(255);
    flash_rd_data = 8'(v);
    flash_rd_valid = 1'b1;
    cyc(1);
    flash_rd_valid = 1'b0;
    twd_host_model_i.idle(4);
    rd('hB4, v);
    cyc(1);
    halted = 1'b0;
    twd_host_model_i.idle(4);
    twd_host_model_i.frame(INS_DATA_WRITE, 8'h06, rv);
    cyc(8);
    chk(8'(got.size()), 0);
    give_verdict;
  end
  initial begin
    #400000;
    err_count++;
    give_verdict;
  end
endmodule
